// >>> dsas_params.svh
// constants for the dual-slope converter sequencer
// assumes a single 10 MHz clock domain
`ifndef DSAS_PARAMS_SVH
`define DSAS_PARAMS_SVH
// ----------------------------------------
// phase lengths in clocks
// ----------------------------------------
`define DSAS_PHASE_LONG    16'h2710
`define DSAS_PHASE_SHORT   16'h03e8
`define DSAS_CNT_W         16
// ----------------------------------------
// reset values
// ----------------------------------------
`define DSAS_CNT_RST       16'h0000
`endif

// >>> dsas_pkg.sv
// types for the dual-slope converter sequencer
// assumes dsas_params.svh is on the include path
package dsas_pkg;
   typedef enum logic [1:0]
   {
      DSAS_AUTO_ZERO = 2'b00,
      DSAS_SIG_INT   = 2'b01,
      DSAS_REF_A     = 2'b10,
      DSAS_REF_B     = 2'b11
   } dsas_phase_type;
endpackage : dsas_pkg

// >>> dsas_sync2.sv
// two flip-flop synchroniser for one level
// assumes the input is asynchronous to clock
`timescale 1ns/100ps
`default_nettype none
module dsas_sync2
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic d,
   output var  logic q
);
   logic s1_reg;
   logic s1_next;
   logic q_next;
   always_comb
   begin
      s1_next = d;
      q_next  = s1_reg;
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s1_reg <= 1'b0;
         q      <= 1'b0;
      end
      else
      begin
         s1_reg <= s1_next;
         q      <= q_next;
      end
   end
endmodule : dsas_sync2
`default_nettype wire

// >>> dsas_sequencer.sv
// digital sequencer of a dual-slope converter: phases, switches, count
// assumes comparator and strap pins are asynchronous, one 10 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "dsas_params.svh"
module dsas_sequencer
   import dsas_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   rst,
   input  wire logic                   comp_in,
   input  wire logic                   range_full,
   input  wire logic                   run_hold,
   output var  logic [5:0]             sw_drive,
   output var  logic                   polarity_pos,
   output var  logic [`DSAS_CNT_W-1:0] result,
   output var  logic                   result_valid,
   output var  logic                   busy,
   output var  logic [1:0]             phase
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic comp_s;
   logic range_s;
   logic run_s;
   dsas_sync2 u_sync_comp  (.clock(clock), .rst(rst), .d(comp_in),    .q(comp_s));
   dsas_sync2 u_sync_range (.clock(clock), .rst(rst), .d(range_full), .q(range_s));
   dsas_sync2 u_sync_run   (.clock(clock), .rst(rst), .d(run_hold),   .q(run_s));

   // ----------------------------------------
   // state
   // ----------------------------------------
   dsas_phase_type         ph_reg, ph_next;
   logic [`DSAS_CNT_W-1:0] pcnt_reg, pcnt_next;
   logic [`DSAS_CNT_W-1:0] cnt_reg, cnt_next;
   logic [`DSAS_CNT_W-1:0] plen_reg, plen_next;
   logic                   zc_reg, zc_next;
   logic                   pol_reg, pol_next;
   logic                   stop_reg, stop_next;
   logic                   hold_reg, hold_next;
   logic [5:0]             sw_next;
   logic [`DSAS_CNT_W-1:0] res_next;
   logic                   rv_next;
   logic                   busy_next;
   logic                   last;
   logic                   in_ref;

   assign last   = (pcnt_reg == plen_reg - `DSAS_CNT_W'(1));
   assign in_ref = (ph_reg == DSAS_REF_A) || (ph_reg == DSAS_REF_B);

   always_comb
   begin
      ph_next   = ph_reg;
      pcnt_next = pcnt_reg;
      cnt_next  = cnt_reg;
      plen_next = plen_reg;
      zc_next   = comp_s;
      pol_next  = pol_reg;
      stop_next = stop_reg;
      hold_next = hold_reg;
      res_next  = result;
      rv_next   = 1'b0;
      if (hold_reg)
      begin
         if (run_s)
         begin
            hold_next = 1'b0;
            pcnt_next = `DSAS_CNT_RST;
            ph_next   = DSAS_AUTO_ZERO;
            plen_next = range_s ? `DSAS_PHASE_LONG : `DSAS_PHASE_SHORT;
         end
      end
      else
      begin
         if (last)
         begin
            pcnt_next = `DSAS_CNT_RST;
            unique case (ph_reg)
               DSAS_AUTO_ZERO: ph_next = DSAS_SIG_INT;
               DSAS_SIG_INT:
               begin
                  ph_next   = DSAS_REF_A;
                  pol_next  = comp_s;
                  cnt_next  = `DSAS_CNT_RST;
                  stop_next = 1'b0;
               end
               DSAS_REF_A:     ph_next = DSAS_REF_B;
               DSAS_REF_B:
               begin
                  ph_next   = DSAS_AUTO_ZERO;
                  hold_next = ~run_s;
                  plen_next = range_s ? `DSAS_PHASE_LONG : `DSAS_PHASE_SHORT;
               end
            endcase
         end
         else
         begin
            pcnt_next = pcnt_reg + `DSAS_CNT_W'(1);
         end
         if (in_ref && !stop_reg)
         begin
            if (pol_reg != zc_reg)
            begin
               stop_next = 1'b1;
            end
            else if (!(ph_reg == DSAS_REF_A && pcnt_reg == `DSAS_CNT_RST))
            begin
               cnt_next = cnt_reg + `DSAS_CNT_W'(1);
            end
         end
         // take the next count so an overload keeps its last reference clock
         if (last && ph_reg == DSAS_REF_B)
         begin
            res_next = cnt_next;
            rv_next  = 1'b1;
         end
      end
      sw_next = 6'h00;
      unique case (ph_next)
         DSAS_AUTO_ZERO: sw_next = 6'h07;
         DSAS_SIG_INT:   sw_next = 6'h08;
         DSAS_REF_A,
         DSAS_REF_B:     sw_next = pol_next ? 6'h20 : 6'h10;
      endcase
      busy_next = ~hold_next;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ph_reg       <= DSAS_AUTO_ZERO;
         pcnt_reg     <= `DSAS_CNT_RST;
         cnt_reg      <= `DSAS_CNT_RST;
         plen_reg     <= `DSAS_PHASE_LONG;
         zc_reg       <= 1'b0;
         pol_reg      <= 1'b0;
         stop_reg     <= 1'b0;
         hold_reg     <= 1'b0;
         sw_drive     <= 6'h07;
         result       <= `DSAS_CNT_RST;
         result_valid <= 1'b0;
         busy         <= 1'b1;
         phase        <= 2'h0;
      end
      else
      begin
         ph_reg       <= ph_next;
         pcnt_reg     <= pcnt_next;
         cnt_reg      <= cnt_next;
         plen_reg     <= plen_next;
         zc_reg       <= zc_next;
         pol_reg      <= pol_next;
         stop_reg     <= stop_next;
         hold_reg     <= hold_next;
         sw_drive     <= sw_next;
         result       <= res_next;
         result_valid <= rv_next;
         busy         <= busy_next;
         phase        <= ph_next;
      end
   end
   assign polarity_pos = pol_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_az_switches: assert property (@(posedge clock) disable iff (rst)
      (phase == 2'h0) |-> (sw_drive == 6'h07)) else $error("auto-zero switches wrong");
   a_si_switches: assert property (@(posedge clock) disable iff (rst)
      (phase == 2'h1) |-> (sw_drive == 6'h08)) else $error("integrate switches wrong");
   a_ref_pos: assert property (@(posedge clock) disable iff (rst)
      (phase[1] && pol_reg) |-> (sw_drive == 6'h20)) else $error("switch six missing");
   a_ref_neg: assert property (@(posedge clock) disable iff (rst)
      (phase[1] && !pol_reg) |-> (sw_drive == 6'h10)) else $error("switch five missing");
   a_phase_order: assert property (@(posedge clock) disable iff (rst)
      (!hold_reg && ph_reg != ph_next) |-> (ph_next == dsas_phase_type'(ph_reg + 2'h1)))
      else $error("phase order broken");
   a_pol_latch: assert property (@(posedge clock) disable iff (rst)
      (ph_reg == DSAS_SIG_INT && last && !hold_reg) |=> (pol_reg == $past(comp_s)))
      else $error("polarity not latched");
   a_pol_hold: assert property (@(posedge clock) disable iff (rst)
      (in_ref && $past(in_ref)) |-> $stable(pol_reg)) else $error("polarity moved");
   a_skip_first: assert property (@(posedge clock) disable iff (rst)
      (ph_reg == DSAS_REF_A && pcnt_reg == `DSAS_CNT_RST) |=> (cnt_reg == `DSAS_CNT_RST))
      else $error("first clock counted");
   a_count_stop: assert property (@(posedge clock) disable iff (rst)
      stop_reg |=> $stable(cnt_reg) || $past(ph_reg == DSAS_SIG_INT))
      else $error("count after stop");
   a_hold_sw: assert property (@(posedge clock) disable iff (rst)
      hold_reg |-> (!busy && sw_drive == 6'h07)) else $error("hold state wrong");
endmodule : dsas_sequencer
`default_nettype wire

// >>> dsas_analog_model.sv
// integrator and comparator model of the analog companion chip
// assumes sw_drive bit n-1 closes switch n
`timescale 1ns/100ps
`default_nettype none
module dsas_analog_model
(
   input  wire logic       clock,
   input  wire logic [5:0] sw_drive,
   input  var  int         v_in,
   input  var  int         ref_step,
   output var  logic       comp_in
);
   int integ = 0;
   // ---
   // integrator
   // ---
   always @(posedge clock)
   begin
      if (sw_drive[2])
         integ <= 0;
      else if (sw_drive[3])
         integ <= integ + v_in;
      else if (sw_drive[5])
         integ <= integ - ref_step;
      else if (sw_drive[4])
         integ <= integ + ref_step;
   end
   assign comp_in = (integ > 0);
endmodule : dsas_analog_model
`default_nettype wire

// >>> test_dual_slope_adc_sequencer.sv
// bench for the converter sequencer with the analog model
// assumes dsas_params.svh is on the include path
`timescale 1ns/100ps
`default_nettype none
`include "dsas_params.svh"
module test_dual_slope_adc_sequencer;
   logic                   clock = 1'b0;
   logic                   rst = 1'b1;
   logic                   range_full = 1'b1;
   logic                   run_hold = 1'b1;
   wire logic              comp_in;
   logic [5:0]             sw_drive;
   logic                   polarity_pos;
   logic                   result_valid;
   logic                   busy;
   logic [`DSAS_CNT_W-1:0] result;
   logic [1:0]             phase;
   int                     v_in = 3;
   int                     ref_step = 10000;
   int                     err_total = 0;
   int                     tests_run = 0;
   int                     cyc = 0;
   int                     n;
   logic [15:0]            r1;
   logic [15:0]            r2;
   logic [5:0]             sw;
   dsas_sequencer dut_u (.clock(clock), .rst(rst), .comp_in(comp_in),
      .range_full(range_full), .run_hold(run_hold), .sw_drive(sw_drive),
      .polarity_pos(polarity_pos), .result(result), .result_valid(result_valid),
      .busy(busy), .phase(phase));
   dsas_analog_model model_u (.clock(clock), .sw_drive(sw_drive), .v_in(v_in),
      .ref_step(ref_step), .comp_in(comp_in));
   always #50 clock = ~clock;
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         err_total++;
         print_verdict();
      end
   end
   // ---
   // helpers
   // ---
   task print_verdict;
      if (err_total == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task chk(input string nm, input logic [15:0] lo, hi, got);
      tests_run++;
      if ((^got === 1'bx) || got < lo || got > hi)
      begin
         err_total++;
         $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask : chk
   task nclk(input int k);
      repeat (k) @(negedge clock);
   endtask : nclk
   task wait_valid;
      int k;
      k = 0;
      nclk(1);
      while (result_valid !== 1'b1 && k < 45000)
      begin
         nclk(1);
         k++;
      end
   endtask : wait_valid
   // length of phase p and the switches one clock into it
   task phase_len(input logic [1:0] p, output int len, output logic [5:0] s);
      int k;
      k = 0;
      while (phase !== p && k < 45000)
      begin
         nclk(1);
         k++;
      end
      nclk(1);
      s = sw_drive;
      len = 1;
      while (phase === p && len < 45000)
      begin
         nclk(1);
         len++;
      end
   endtask : phase_len
   task measure(input int v, output logic [15:0] res, output logic [5:0] s);
      v_in = v;
      phase_len(2'h1, n, s);
      chk("signal phase", `DSAS_PHASE_SHORT, `DSAS_PHASE_SHORT, n[15:0]);
      chk("signal switch", 16'h0008, 16'h0008, {10'h0, s});
      phase_len(2'h2, n, s);
      chk("ref phase", `DSAS_PHASE_SHORT, `DSAS_PHASE_SHORT, n[15:0]);
      wait_valid();
      res = result;
      chk("busy", 16'h0001, 16'h0001, {15'h0, busy});
      chk("polarity", {15'h0, v > 0}, {15'h0, v > 0}, {15'h0, polarity_pos});
   endtask : measure
   task t_hold;
      run_hold = 1'b0;
      nclk(200);
      run_hold = 1'b1;
      nclk(4);
      run_hold = 1'b0;
      wait_valid();
      nclk(1500);
      chk("held state", 16'h0007, 16'h0007, {7'h0, busy, phase, sw_drive});
      run_hold = 1'b1;
      nclk(4);
      run_hold = 1'b0;
      phase_len(2'h1, n, sw);
      chk("restart", `DSAS_PHASE_SHORT, `DSAS_PHASE_SHORT, n[15:0]);
   endtask : t_hold
   task t_reset;
      nclk(2);
      chk("reset state", 16'h001c, 16'h001c,
         {6'h0, phase, sw_drive, polarity_pos, result_valid});
      chk("reset result", 16'h0000, 16'h0000, result);
      rst = 1'b0;
   endtask : t_reset
   task t_long;
      phase_len(2'h1, n, sw);
      chk("long phase", `DSAS_PHASE_LONG, `DSAS_PHASE_LONG, n[15:0]);
      phase_len(2'h2, n, sw);
      chk("long ref", `DSAS_PHASE_LONG, `DSAS_PHASE_LONG, n[15:0]);
      chk("positive switch", 16'h0020, 16'h0020, {10'h0, sw});
      range_full = 1'b0;
      ref_step = 1000;
      wait_valid();
      chk("long reading", 16'h0003, 16'h0007, result);
   endtask : t_long
   task t_readings;
      measure(300, r1, sw);
      chk("reading", 16'h0128, 16'h0132, r1);
      measure(700, r2, sw);
      chk("reading step", r1 + 16'h0190, r1 + 16'h0190, r2);
      measure(-500, r2, sw);
      chk("negative switch", 16'h0010, 16'h0010, {10'h0, sw});
      chk("negative reading", 16'h01ee, 16'h01fa, r2);
      measure(2500, r2, sw);
      chk("overload", 16'h07cf, 16'h07cf, r2);
   endtask : t_readings
   // ---
   // main sequence
   // ---
   initial
   begin
      t_reset();
      t_long();
      t_readings();
      t_hold();
      print_verdict();
   end
endmodule : test_dual_slope_adc_sequencer
`default_nettype wire
